// ==== pkg/slc_pkg.sv ====
// How it works
// R1 - Bias divider off whenever the driver is off
// R2 - Each RAM bit maps to one fixed element
// R3 - Set bit turns element on, clear keeps off
// R4 - RAM E0..F7, six bytes per backplane
// R5 - First byte S8..S4 high, then eight per byte
// R6 - Display RAM is not reset
// R7 - Unused backplane bytes are plain storage
// R8 - Main clock source plus stop switches off
// R9 - Switched off by stop grounds every line
// R10 - Auxiliary source keeps display running in stop
// R11 - Source or function change waits for frame end
// R12 - Software waits for frame end before stop
// R13 - Clock field: off, aux, reserved, main divide
// R14 - Mode register DCh: mux, clock, frame fields
// R15 - Mux field sets number of scanned backplanes
// R16 - Frame field divides reference 512 down to 64
// R17 - Mux codes 00=4, 01=1, 10=2, 11=3
// R18 - Main clock divided by 32..256 for reference
// R19 - Frame rate is base rate over backplanes
// R20 - Oscillator failure grounds every line
// R21 - Segments follow scanned backplane, slot per period
package slc_pkg;

  // ==========================================================
  // Register map
  localparam logic [7:0] SLC_MODE_ADDR   = 8'hDC;
  localparam logic [7:0] SLC_STAT_ADDR   = 8'hDE;
  localparam logic [7:0] SLC_RAM_FIRST   = 8'hE0;
  localparam logic [7:0] SLC_RAM_LAST    = 8'hF7;
  localparam logic [7:0] SLC_MODE_RESET  = 8'h00;
  localparam logic [7:0] SLC_READ_NONE   = 8'h00;

  // ==========================================================
  // Field positions of the mode register
  localparam int SLC_MUX_MSB = 7;
  localparam int SLC_MUX_LSB = 6;
  localparam int SLC_CLK_MSB = 5;
  localparam int SLC_CLK_LSB = 3;
  localparam int SLC_FR_MSB  = 2;
  localparam int SLC_FR_LSB  = 0;

  // ==========================================================
  // Geometry
  localparam int SLC_RAM_BYTES   = 24;
  localparam int SLC_GROUP_BYTES = 6;
  localparam int SLC_SEG_LINES   = 45;
  localparam int SLC_BACKPLANES  = 4;
  localparam int SLC_DIV_W       = 10;

  // ==========================================================
  // Clock field codes and the reserved frame code
  localparam logic [2:0] SLC_CLK_OFF   = 3'h0;
  localparam logic [2:0] SLC_CLK_AUX   = 3'h1;
  localparam logic [2:0] SLC_CLK_RSV_A = 3'h2;
  localparam logic [2:0] SLC_CLK_RSV_B = 3'h7;
  localparam logic [2:0] SLC_FR_RSV    = 3'h7;

  typedef enum logic [2:0] {
    SLC_ST_IDLE = 3'b001,
    SLC_ST_SCAN = 3'b010,
    SLC_ST_HALT = 3'b100
  } slc_state_e;

  // Main clock division to the reference; zero means no main source
  function automatic logic [SLC_DIV_W-1:0] slc_main_div(
    input logic [2:0] code
  );
    case (code)
      3'h3:    slc_main_div = 10'h020; // [R18]
      3'h4:    slc_main_div = 10'h040; // [R18]
      3'h5:    slc_main_div = 10'h080; // [R18]
      3'h6:    slc_main_div = 10'h100; // [R18]
      default: slc_main_div = 10'h000;
    endcase
  endfunction : slc_main_div

  function automatic logic [SLC_DIV_W-1:0] slc_frame_div(
    input logic [2:0] code
  );
    case (code)
      3'h0:    slc_frame_div = 10'h200; // [R16]
      3'h1:    slc_frame_div = 10'h182; // [R16]
      3'h2:    slc_frame_div = 10'h100; // [R16]
      3'h3:    slc_frame_div = 10'h0C0; // [R16]
      3'h4:    slc_frame_div = 10'h080; // [R16]
      3'h5:    slc_frame_div = 10'h060; // [R16]
      3'h6:    slc_frame_div = 10'h040; // [R16]
      default: slc_frame_div = 10'h000;
    endcase
  endfunction : slc_frame_div

  // Index of the last scanned backplane
  function automatic logic [1:0] slc_last_slot(input logic [1:0] mux);
    case (mux)
      2'h0:    slc_last_slot = 2'h3; // [R17]
      2'h1:    slc_last_slot = 2'h0; // [R17]
      2'h2:    slc_last_slot = 2'h1; // [R17]
      default: slc_last_slot = 2'h2; // [R17]
    endcase
  endfunction : slc_last_slot

endpackage : slc_pkg

// ==== rtl/slc_lcd_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
module slc_lcd_ctrl
  import slc_pkg::*;
(
  input  wire logic                     clock,
  input  wire logic                     rst_n,
  input  wire logic                     clk_en,
  input  wire logic [7:0]               addr,
  input  wire logic [7:0]               wr_data,
  input  wire logic                     wr_en,
  input  wire logic                     rd_en,
  output logic [7:0]                    rd_data,
  input  wire logic                     stop_req,
  input  wire logic                     aux_low_speed_oscillator,
  input  wire logic                     osc_fail,
  output logic [SLC_SEG_LINES-1:0]      seg_out,
  output logic                          backplane_out_1,
  output logic                          backplane_out_2,
  output logic                          backplane_out_3,
  output logic                          backplane_out_4,
  output logic                          frame_phase,
  output logic                          lines_grounded,
  output logic                          bias_div_en
);

  // ==========================================================
  // Storage
  logic [7:0]               ram_q [0:SLC_RAM_BYTES-1];
  logic [7:0]               mode_q;
  logic [7:0]               act_q;
  logic [1:0]               slot_q;
  logic                     phase_q;
  slc_state_e               state_q;
  slc_state_e               state_d;

  // Synchronisers for pins from outside the clock domain
  logic                     aux_s1_q;
  logic                     aux_s2_q;
  logic                     aux_s3_q;
  logic                     fail_s1_q;
  logic                     fail_s2_q;

  // ==========================================================
  // Bus decode
  wire                      ram_hit;
  wire [7:0]                ram_off;
  wire [4:0]                ram_idx;
  wire                      mode_hit;
  wire                      stat_hit;
  wire [7:0]                stat_val;
  wire [7:0]                rd_mux;

  assign ram_hit  = (addr >= SLC_RAM_FIRST) && (addr <= SLC_RAM_LAST); // [R4]
  assign ram_off  = addr - SLC_RAM_FIRST;
  assign ram_idx  = ram_off[4:0];
  assign mode_hit = (addr == SLC_MODE_ADDR); // [R14]
  assign stat_hit = (addr == SLC_STAT_ADDR);

  // Unused backplane bytes read back exactly as written
  assign rd_mux = ram_hit  ? ram_q[ram_idx] : // [R7]
                  mode_hit ? mode_q :         // [R14]
                  stat_hit ? stat_val :
                             SLC_READ_NONE;

  // ==========================================================
  // Active configuration fields
  wire [1:0]                act_mux;
  wire [2:0]                act_clk;
  wire [2:0]                act_fr;
  wire [SLC_DIV_W-1:0]      main_div;
  wire [SLC_DIV_W-1:0]      frame_div;
  wire [1:0]                last_slot;
  wire                      src_aux;
  wire                      src_main;
  wire                      cfg_runnable;

  assign act_mux   = act_q[SLC_MUX_MSB:SLC_MUX_LSB];
  assign act_clk   = act_q[SLC_CLK_MSB:SLC_CLK_LSB];
  assign act_fr    = act_q[SLC_FR_MSB:SLC_FR_LSB];
  assign main_div  = slc_main_div(act_clk);   // [R18]
  assign frame_div = slc_frame_div(act_fr);   // [R16]
  assign last_slot = slc_last_slot(act_mux);  // [R15]

  // Off and reserved codes leave no source selected
  assign src_aux  = (act_clk == SLC_CLK_AUX);       // [R13]
  assign src_main = (main_div != 10'h000);          // [R13]
  assign cfg_runnable = (src_aux || src_main) &&
                        (act_fr != SLC_FR_RSV);

  assign stat_val = {2'h0, slot_q, phase_q, fail_s2_q,
                     src_aux, state_q == SLC_ST_SCAN};

  // ==========================================================
  // Reference and base frame ticks
  wire                      aux_edge;
  wire                      scanning;
  wire                      main_tick;
  wire                      ref_step;
  wire                      base_tick;
  wire                      frame_end;

  assign aux_edge = aux_s2_q && !aux_s3_q;
  assign scanning = (state_q == SLC_ST_SCAN);

  slc_tick_div u_ref_div (
    .clock  (clock),
    .rst_n  (rst_n),
    .clk_en (clk_en),
    .run    (scanning && src_main),
    .step   (1'b1),
    .divide (main_div),
    .tick   (main_tick)
  );

  assign ref_step = src_aux ? aux_edge : main_tick; // [R10]

  slc_tick_div u_base_div (
    .clock  (clock),
    .rst_n  (rst_n),
    .clk_en (clk_en),
    .run    (scanning),
    .step   (ref_step),
    .divide (frame_div),
    .tick   (base_tick)
  );

  // A frame ends after the last active backplane slot
  assign frame_end = base_tick && (slot_q == last_slot); // [R19]

  // ==========================================================
  // Driver state
  wire                      stop_kills;
  wire                      apply_cfg;

  // Main source has no clock in stop; auxiliary keeps going
  assign stop_kills = stop_req && !src_aux; // [R8] [R10]

  // An idle driver has no frame to wait for, so it takes the
  // new mode at once; a scanning one only at frame end
  assign apply_cfg = frame_end || (state_q == SLC_ST_IDLE); // [R11]

  always_comb begin
    state_d = state_q;
    case (state_q)
      SLC_ST_IDLE: begin
        if (cfg_runnable && !fail_s2_q && !stop_kills) begin
          state_d = SLC_ST_SCAN;
        end
      end
      SLC_ST_SCAN: begin
        if (!cfg_runnable) begin
          state_d = SLC_ST_IDLE; // [R13]
        end else if (stop_kills || fail_s2_q) begin
          state_d = SLC_ST_HALT; // [R8] [R12] [R20]
        end
      end
      SLC_ST_HALT: begin
        if (!stop_kills && !fail_s2_q) begin
          state_d = SLC_ST_SCAN;
        end
      end
      default: state_d = SLC_ST_IDLE;
    endcase
  end

  // ==========================================================
  // Segment row of the backplane being scanned; the RAM bytes are
  // direct operands so a write during scan shows on the next cycle
  wire [4:0]                row_base;
  wire [SLC_SEG_LINES-1:0]  row_now;
  wire [3:0]                bp_sel;
  wire                      drive_on;

  assign row_base = 5'(slot_q) * 5'(SLC_GROUP_BYTES); // [R4]
  assign row_now  = {ram_q[row_base + 5'h5], ram_q[row_base + 5'h4],
                     ram_q[row_base + 5'h3], ram_q[row_base + 5'h2],
                     ram_q[row_base + 5'h1],
                     ram_q[row_base][7:3]}; // [R2] [R5]
  assign bp_sel   = 4'h1 << slot_q;
  assign drive_on = (state_d == SLC_ST_SCAN);

  // ==========================================================
  // Synchronisers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      aux_s1_q  <= 1'b0;
      aux_s2_q  <= 1'b0;
      aux_s3_q  <= 1'b0;
      fail_s1_q <= 1'b0;
      fail_s2_q <= 1'b0;
    end else if (clk_en) begin
      aux_s1_q  <= aux_low_speed_oscillator;
      aux_s2_q  <= aux_s1_q;
      aux_s3_q  <= aux_s2_q;
      fail_s1_q <= osc_fail;
      fail_s2_q <= fail_s1_q;
    end
  end

  // ==========================================================
  // Display RAM has no reset on purpose
  always_ff @(posedge clock) begin
    if (clk_en && wr_en && ram_hit) begin
      ram_q[ram_idx] <= wr_data; // [R6] [R7]
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mode_q  <= SLC_MODE_RESET;
      act_q   <= SLC_MODE_RESET;
      rd_data <= SLC_READ_NONE;
    end else if (clk_en) begin
      if (wr_en && mode_hit) begin
        mode_q <= wr_data; // [R14]
      end
      if (apply_cfg) begin
        act_q <= mode_q; // [R11]
      end
      rd_data <= rd_en ? rd_mux : SLC_READ_NONE;
    end
  end

  // ==========================================================
  // Scan sequencer
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= SLC_ST_IDLE;
      slot_q  <= 2'h0;
      phase_q <= 1'b0;
    end else if (clk_en) begin
      state_q <= state_d;
      if (state_d != SLC_ST_SCAN) begin
        slot_q <= 2'h0;
      end else if (frame_end) begin
        slot_q  <= 2'h0;       // [R19]
        phase_q <= !phase_q;   // Flip polarity so no DC builds up
      end else if (base_tick) begin
        slot_q <= slot_q + 2'h1; // [R21]
      end
    end
  end

  // ==========================================================
  // Line drivers; everything grounded when not scanning
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      seg_out         <= '0;
      backplane_out_1 <= 1'b0;
      backplane_out_2 <= 1'b0;
      backplane_out_3 <= 1'b0;
      backplane_out_4 <= 1'b0;
      frame_phase     <= 1'b0;
      lines_grounded  <= 1'b1;
      bias_div_en     <= 1'b0;
    end else if (clk_en) begin
      seg_out         <= drive_on ? row_now : '0; // [R3] [R9] [R20]
      backplane_out_1 <= drive_on && bp_sel[0];   // [R21]
      backplane_out_2 <= drive_on && bp_sel[1];
      backplane_out_3 <= drive_on && bp_sel[2];
      backplane_out_4 <= drive_on && bp_sel[3];
      frame_phase     <= drive_on && phase_q;
      lines_grounded  <= !drive_on;               // [R9] [R20]
      bias_div_en     <= drive_on;                // [R1]
    end
  end

endmodule : slc_lcd_ctrl
`default_nettype wire

// ==== rtl/slc_tick_div.sv ====
`timescale 1ns/1ps
`default_nettype none
module slc_tick_div
  import slc_pkg::*;
(
  input  wire logic                 clock,
  input  wire logic                 rst_n,
  input  wire logic                 clk_en,
  input  wire logic                 run,
  input  wire logic                 step,
  input  wire logic [SLC_DIV_W-1:0] divide,
  output logic                      tick
);

  logic [SLC_DIV_W-1:0] cnt_q;
  logic                 wrap;

  // ==========================================================
  // Count steps; one pulse every divide steps
  assign wrap = (cnt_q >= divide - 10'h001);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 10'h000;
      tick  <= 1'b0;
    end else if (clk_en) begin
      if (!run || divide == 10'h000) begin
        cnt_q <= 10'h000;
        tick  <= 1'b0;
      end else if (step) begin
        cnt_q <= wrap ? 10'h000 : cnt_q + 10'h001;
        tick  <= wrap;
      end else begin
        tick  <= 1'b0;
      end
    end
  end

endmodule : slc_tick_div
`default_nettype wire

// ==== verif/slc_glass_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module slc_glass_model
  import slc_pkg::*;
(
  input wire logic                     clock,
  input wire logic [SLC_SEG_LINES-1:0] seg_out,
  input wire logic [3:0]               bp,
  input wire logic                     lines_grounded,
  output logic [SLC_SEG_LINES-1:0]     lit [4]
);
  // ==========
  // Passive glass: remembers the pattern shown under each backplane
  always_ff @(posedge clock) begin
    for (int k = 0; k < 4; k++) begin
      if (bp[k] && !lines_grounded) lit[k] <= seg_out;
    end
  end
endmodule : slc_glass_model
`default_nettype wire

// ==== verif/slc_lcd_ctrl_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module slc_lcd_ctrl_bench;
  import slc_pkg::*;
  logic                     clock = 0, rst_n = 0, clk_en = 1;
  logic                     wr_en = 0, rd_en = 0, stop_req = 0;
  logic                     aux = 0, osc_fail = 0;
  logic [7:0]               addr = 0, wr_data = 0, rd_data;
  logic [SLC_SEG_LINES-1:0] seg_out;
  logic [SLC_SEG_LINES-1:0] lit [4];
  logic                     b1, b2, b3, b4, frame_phase;
  logic                     lines_grounded, bias_div_en, gnd;
  logic [3:0]               seen;
  int err_count = 0, checked = 0, cyc = 0, n;
  int ram [SLC_RAM_BYTES];
  int divs [7] = '{512, 386, 256, 192, 128, 96, 64};
  wire logic [3:0] bp = {b4, b3, b2, b1};

  always #4 clock = ~clock;
  // Auxiliary reference: one rising edge every four clocks
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc[0]) aux <= ~aux;
    if (cyc == 90000) begin
      err_count++;
      close_out();
    end
  end

  slc_lcd_ctrl dut (
    .clock(clock), .rst_n(rst_n), .clk_en(clk_en), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .stop_req(stop_req), .aux_low_speed_oscillator(aux),
    .osc_fail(osc_fail), .seg_out(seg_out), .backplane_out_1(b1),
    .backplane_out_2(b2), .backplane_out_3(b3), .backplane_out_4(b4),
    .frame_phase(frame_phase), .lines_grounded(lines_grounded),
    .bias_div_en(bias_div_en));
  slc_glass_model glass (.clock(clock), .seg_out(seg_out), .bp(bp),
    .lines_grounded(lines_grounded), .lit(lit));

  // ==========
  // Tasks
  task close_out();
    if (err_count == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : close_out
  task chk(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : chk
  task step(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask : step
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    #1;
    chk(rd_data, exp);
  endtask : rd
  // Cycles until backplane k next rises, left in n
  task wait_bp(input int k);
    n = 0;
    while (bp[k] !== 1'b0 && n < 20000) begin
      step(1);
      n++;
    end
    while (bp[k] !== 1'b1 && n < 20000) begin
      step(1);
      n++;
    end
    if (n >= 20000) begin
      err_count++;
      close_out();
    end
  endtask : wait_bp
  task observe(input int c);
    seen = '0;
    gnd = 1'b0;
    repeat (c) begin
      step(1);
      seen |= bp;
      gnd |= lines_grounded;
    end
  endtask : observe
  function automatic logic [SLC_SEG_LINES-1:0] expseg(input int k);
    logic [7:0] b;
    expseg = '0;
    b = 8'(ram[6*k]);
    expseg[4:0] = b[7:3];
    for (int j = 1; j < 6; j++) expseg[8*j+4 -: 8] = 8'(ram[6*k+j]);
  endfunction : expseg

  // ==========
  // Main sequence
  initial begin
    void'($urandom(32'hA78DE24D));
    step(12);
    rst_n <= 1'b1;
    rd(SLC_MODE_ADDR, SLC_MODE_RESET);
    chk({lines_grounded, bias_div_en}, 2'b10);
    foreach (ram[i]) begin
      ram[i] = int'($urandom % 256);
      wr(8'(SLC_RAM_FIRST + i), 8'(ram[i]));
    end
    foreach (ram[i]) rd(8'(SLC_RAM_FIRST + i), 8'(ram[i]));
    wr(8'hDD, 8'h5A);
    rd(8'hDD, 8'h00);
    rd(8'hF8, 8'h00);
    clk_en <= 1'b0;
    wr(SLC_RAM_FIRST, 8'(ram[0]) ^ 8'hFF);
    clk_en <= 1'b1;
    rd(SLC_RAM_FIRST, 8'(ram[0]));
    wr(SLC_MODE_ADDR, 8'h1E);
    rd(SLC_MODE_ADDR, 8'h1E);
    wait_bp(1);
    wait_bp(2);
    chk(n, 2048);
    wait_bp(0);
    chk(n, 4096);
    for (int k = 0; k < 4; k++) chk(lit[k], expseg(k));
    chk(bias_div_en, 1'b1);
    wr(SLC_MODE_ADDR, 8'h0E);
    wait_bp(1);
    chk(n > 2000, 1'b1);
    wait_bp(0);
    for (int m = 0; m < 4; m++) begin
      wr(SLC_MODE_ADDR, 8'(m * 64 + 8'h0E));
      step(1300);
      observe(1100);
      chk(seen, (m == 0) ? 4'hF : 4'((1 << m) - 1));
    end
    for (int f = 0; f < 7; f++) begin
      wr(SLC_MODE_ADDR, 8'(8'h88 + f));
      wait_bp(0);
      wait_bp(1);
      chk(n, divs[f] * 4);
    end
    stop_req <= 1'b1;
    observe(600);
    chk({seen, gnd}, 5'b00110);
    stop_req <= 1'b0;
    wr(SLC_MODE_ADDR, 8'h1E);
    step(800);
    stop_req <= 1'b1;
    step(3);
    chk({lines_grounded, bp, seg_out}, 64'h1 << 49);
    stop_req <= 1'b0;
    osc_fail <= 1'b1;
    step(6);
    chk(lines_grounded, 1'b1);
    osc_fail <= 1'b0;
    wr(SLC_MODE_ADDR, 8'h00);
    step(8400);
    chk({lines_grounded, bias_div_en}, 2'b10);
    foreach (divs[i]) begin
      if (i < 3) begin
        wr(SLC_MODE_ADDR, (i == 0) ? 8'h10 : (i == 1) ? 8'h38 : 8'h1F);
        step(4);
        chk(lines_grounded, 1'b1);
      end
    end
    rd(SLC_MODE_ADDR, 8'h1F);
    close_out();
  end
endmodule : slc_lcd_ctrl_bench
`default_nettype wire

// ==== verif/slc_lcd_ctrl_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module slc_chk
  import slc_pkg::*;
(
  input wire logic                     clock,
  input wire logic                     rst_n,
  input wire logic                     clk_en,
  input wire logic [7:0]               addr,
  input wire logic [7:0]               wr_data,
  input wire logic                     wr_en,
  input wire logic                     rd_en,
  input wire logic [7:0]               rd_data,
  input wire logic                     stop_req,
  input wire logic                     osc_fail,
  input wire logic [SLC_SEG_LINES-1:0] seg_out,
  input wire logic                     backplane_out_1,
  input wire logic                     backplane_out_2,
  input wire logic                     backplane_out_3,
  input wire logic                     backplane_out_4,
  input wire logic                     frame_phase,
  input wire logic                     lines_grounded,
  input wire logic                     bias_div_en
);
  // ==========
  // Shadow of what software wrote
  logic [7:0]               mode_q;
  logic [7:0]               ram_q [SLC_RAM_BYTES];
  logic [SLC_RAM_BYTES-1:0] valid_q;
  wire logic [4:0] ram_idx = 5'(addr - SLC_RAM_FIRST);
  wire logic       in_ram  = (addr >= SLC_RAM_FIRST) &&
                             (addr <= SLC_RAM_LAST);
  wire logic [7:0] ram_now = ram_q[ram_idx];
  wire logic [3:0] bp      = {backplane_out_4, backplane_out_3,
                              backplane_out_2, backplane_out_1};
  wire logic [2:0] src     = mode_q[SLC_CLK_MSB:SLC_CLK_LSB];
  wire logic       main_src = (src >= 3'h3) && (src <= 3'h6);
  wire logic       wr_ok   = wr_en && clk_en;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mode_q  <= SLC_MODE_RESET;
      valid_q <= '0;
    end else if (wr_ok) begin
      if (addr == SLC_MODE_ADDR) mode_q <= wr_data;
      if (in_ram) valid_q[ram_idx] <= 1'b1;
    end
  end
  // Display RAM has no reset, so neither has its shadow
  always_ff @(posedge clock) begin
    if (wr_ok && in_ram) ram_q[ram_idx] <= wr_data;
  end

  // ==========
  // Assertions
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_grounded_dark: assert property (
    lines_grounded |-> seg_out == '0 && bp == 4'h0 && !frame_phase)
    else $error("grounded lines still driven");
  a_bias_off: assert property (lines_grounded |-> !bias_div_en)
    else $error("bias divider on while driver off");
  a_bp_onehot: assert property ($onehot0(bp))
    else $error("more than one backplane active");
  a_read_idle: assert property (!$past(rd_en) |-> rd_data == 8'h00)
    else $error("read data outside its cycle");
  a_mode_readback: assert property (
    rd_en && clk_en && addr == SLC_MODE_ADDR |=> rd_data == $past(mode_q))
    else $error("mode register readback wrong");
  a_ram_readback: assert property (
    rd_en && clk_en && in_ram && valid_q[ram_idx]
    |=> rd_data == $past(ram_now))
    else $error("display RAM readback wrong");
  a_unmapped_zero: assert property (
    rd_en && clk_en && !in_ram && addr != SLC_MODE_ADDR
    && addr != SLC_STAT_ADDR |=> rd_data == 8'h00)
    else $error("unmapped read not zero");
  a_stop_ground: assert property (
    $rose(stop_req) && main_src |-> ##[1:2] lines_grounded)
    else $error("stop with main source did not ground");
  a_fail_ground: assert property (osc_fail [*6] |-> lines_grounded)
    else $error("oscillator failure did not ground");
  a_phase_frame: assert property (
    $changed(frame_phase) && !lines_grounded && !$past(lines_grounded)
    |-> backplane_out_1)
    else $error("polarity flipped inside a frame");

  c_last_bp: cover property ($rose(backplane_out_4));
  c_aux_stop: cover property (stop_req && !lines_grounded && bp != 4'h0);
  c_fail: cover property ($rose(osc_fail) ##5 lines_grounded);
endmodule : slc_chk

bind slc_lcd_ctrl slc_chk u_chk (
  .clock(clock), .rst_n(rst_n), .clk_en(clk_en), .addr(addr),
  .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
  .stop_req(stop_req), .osc_fail(osc_fail), .seg_out(seg_out),
  .backplane_out_1(backplane_out_1), .backplane_out_2(backplane_out_2),
  .backplane_out_3(backplane_out_3), .backplane_out_4(backplane_out_4),
  .frame_phase(frame_phase), .lines_grounded(lines_grounded),
  .bias_div_en(bias_div_en));
`default_nettype wire
